/* logic/wtt_ctl.sv */
// Controller end: APB command register, spacing counters, command issue.
// Assumes APB from software and a device that obeys mode sets it is sent.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module wtt_ctl
    import wtt_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // Command path
    wtt_cmd_if.ctl            cif
);

    typedef struct packed {
        logic                       pready;
        logic [31:0]                prdata;
        logic                       pslverr;
        logic                       pend;
        logic                       blocked;
        wtt_cmd_t                   pcmd;
        logic [1:0]                 pbg;
        logic [1:0]                 pba;
        logic                       pbc;
        logic                       pap;
        logic [15:0]                padr;
        logic [CW-1:0]              write_recovery_time;
        logic [CW-1:0]              write_recovery_inverted;
        logic [CW-1:0]              wtr_s;
        logic [CW-1:0]              wtr_l;
        logic [CW-1:0]              activate_to_precharge_min;
        logic [1:0]                 bm;
        logic                       data_bus_inversion;
        logic [CW-1:0]              al;
        logic [CW-1:0]              cas_write_latency;
        logic                       cvalid;
        wtt_cmd_t                   ccmd;
        logic [1:0]                 cbg;
        logic [1:0]                 cba;
        logic                       cbc;
        logic                       cap;
        logic [15:0]                cadr;
        logic [NBANK-1:0][CW-1:0]   pre_cnt;
        logic [NBANK-1:0][CW-1:0]   ras_cnt;
        logic [NBG-1:0][CW-1:0]     rdl_cnt;
        logic [CW-1:0]              rds_cnt;
    } wtt_ctl_st_t;

    wtt_ctl_st_t q;
    wtt_ctl_st_t d;

    // Counters, issue decision and APB register file
    always_comb begin
        logic [CW-1:0] wl;
        logic [CW-1:0] dend;
        logic [CW-1:0] rec;
        logic [3:0]    bank;
        logic          ok;
        logic          acc;
        wl   = '0;
        dend = '0;
        rec  = '0;
        bank = '0;
        ok   = 1'b0;
        acc  = 1'b0;
        d         = q;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.cvalid  = 1'b0;
        d.ccmd    = CMD_DES;
        // every hold-off counter runs down to zero
        for (int i = 0; i < NBANK; i++) begin
            if (q.pre_cnt[i] != '0) d.pre_cnt[i] = q.pre_cnt[i] - 8'h01;
            if (q.ras_cnt[i] != '0) d.ras_cnt[i] = q.ras_cnt[i] - 8'h01;
        end
        for (int g = 0; g < NBG; g++) begin
            if (q.rdl_cnt[g] != '0) d.rdl_cnt[g] = q.rdl_cnt[g] - 8'h01;
        end
        if (q.rds_cnt != '0) d.rds_cnt = q.rds_cnt - 8'h01;

        // write latency from the mode shadow
        wl   = q.al + q.cas_write_latency;
        // reference edge after fixed chop or eight beats
        dend = wl + ((q.bm == BM_CHOP4) ? END_FIXED : END_EIGHT);
        // inverted recovery when inversion is on
        rec  = q.data_bus_inversion ? q.write_recovery_inverted : q.write_recovery_time;
        bank = {q.pbg, q.pba};

        // Gate only dependent commands
        case (q.pcmd)
            // short for any group, long for its own
            CMD_RD:  ok = (q.rdl_cnt[q.pbg] == '0) && (q.rds_cnt == '0);
            // recovery and activate minimum both gone
            CMD_PRE: ok = (q.pre_cnt[bank] == '0) && (q.ras_cnt[bank] == '0);
            default: ok = 1'b1;
        endcase
        d.blocked = q.pend && !ok;

        // Issue; loads are one less since issue is one edge late
        if (q.pend && ok) begin
            d.pend   = 1'b0;
            d.cvalid = 1'b1;
            d.ccmd   = q.pcmd;
            d.cbg    = q.pbg;
            d.cba    = q.pba;
            d.cbc    = q.pbc;
            d.cap    = q.pap;
            d.cadr   = q.padr;
            case (q.pcmd)
                CMD_MRS: begin
                    // Shadow of what the device will hold
                    d.bm  = q.padr[MB_BM_LO +: 2];
                    d.data_bus_inversion = q.padr[MB_DBI];
                    d.cas_write_latency = CW'(q.padr[MB_CWL_LO +: MB_LAT_W]);
                    d.al  = CW'(q.padr[MB_AL_LO +: MB_LAT_W]);
                end
                CMD_ACT: begin
                    d.ras_cnt[bank] = wtt_max(d.ras_cnt[bank],
                                              q.activate_to_precharge_min - 8'h01);
                end
                CMD_WR: begin
                    // precharge hold, also covers auto precharge
                    d.pre_cnt[bank] = wtt_max(d.pre_cnt[bank],
                                              dend + rec - 8'h01);
                    // long wait in the written group
                    d.rdl_cnt[q.pbg] = wtt_max(d.rdl_cnt[q.pbg],
                                               dend + q.wtr_l - 8'h01);
                    d.rds_cnt = wtt_max(d.rds_cnt, dend + q.wtr_s - 8'h01);
                end
                default: begin
                    d.cvalid = 1'b1;
                end
            endcase
        end

        // APB access phase; pready is registered, so one wait state
        acc = psel && penable && !q.pready;
        if (acc && pwrite) begin
            if (paddr == REG_CMD) begin
                // Held off while a command still waits: back-pressure
                if (!d.pend) begin
                    d.pend   = 1'b1;
                    d.pcmd   = wtt_cmd_t'(pwdata[CF_CMD_LO +: 3]);
                    d.pba    = pwdata[CF_BA_LO +: 2];
                    d.pbg    = pwdata[CF_BG_LO +: 2];
                    d.pbc    = pwdata[CF_BC];
                    d.pap    = pwdata[CF_AP];
                    d.padr   = pwdata[CF_ADR_LO +: 16];
                    d.pready = 1'b1;
                end
            end else if (paddr == REG_TIM) begin
                d.write_recovery_time     = pwdata[7:0];
                d.write_recovery_inverted = pwdata[15:8];
                d.wtr_s   = pwdata[23:16];
                d.wtr_l   = pwdata[31:24];
                d.pready  = 1'b1;
            end else if (paddr == REG_ACTIVATE_TO_PRECHARGE_MIN) begin
                d.activate_to_precharge_min   = pwdata[7:0];
                d.pready = 1'b1;
            end else begin
                d.pready  = 1'b1;
                d.pslverr = 1'b1;
            end
        end else if (acc) begin
            d.pready = 1'b1;
            d.prdata = '0;
            if (paddr == REG_CMD) begin
                d.prdata = {q.padr, 7'h00, q.pap, q.pbc, q.pbg, q.pba,
                            q.pcmd};
            end else if (paddr == REG_TIM) begin
                d.prdata = {q.wtr_l, q.wtr_s, q.write_recovery_inverted, q.write_recovery_time};
            end else if (paddr == REG_ACTIVATE_TO_PRECHARGE_MIN) begin
                d.prdata = {24'h000000, q.activate_to_precharge_min};
            end else if (paddr == REG_STAT) begin
                d.prdata = {q.al, q.cas_write_latency, 9'h000, q.data_bus_inversion, q.bm,
                            1'b0, (q.pre_cnt != '0), q.blocked, q.pend};
            end else begin
                d.pslverr = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q         <= '0;
            q.write_recovery_time     <= TWR_RST;
            q.write_recovery_inverted <= WRITE_RECOVERY_INVERTED_RST;
            q.wtr_s   <= WTR_S_RST;
            q.wtr_l   <= WTR_L_RST;
            q.activate_to_precharge_min    <= ACTIVATE_TO_PRECHARGE_MIN_RST;
            q.cas_write_latency     <= CWL_RST;
            q.al      <= AL_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign pready        = q.pready;
    assign prdata        = q.prdata;
    assign pslverr       = q.pslverr;
    assign cif.cmd_valid = q.cvalid;
    assign cif.cmd       = q.ccmd;
    assign cif.bg        = q.cbg;
    assign cif.ba        = q.cba;
    assign cif.bc_bit    = q.cbc;
    assign cif.ap        = q.cap;
    assign cif.addr      = q.cadr;

endmodule // wtt_ctl

/* logic/wtt_pkg.sv */
// Shared constants and types for the write turnaround timing pair.
// Assumes one clock for both ends and a four-by-four bank organisation.
package wtt_pkg;

    // Bank organisation and counter width
    localparam int NBG   = 4;
    localparam int NBK   = 4;
    localparam int NBANK = NBG * NBK;
    localparam int CW    = 8;

    // Command set on the command/address path
    typedef enum logic [2:0] {
        CMD_DES,
        CMD_MRS,
        CMD_ACT,
        CMD_WR,
        CMD_RD,
        CMD_PRE
    } wtt_cmd_t;

    // Per-bank tracker phases inside the device
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_DATA,
        PH_REC
    } wtt_ph_t;

    // Burst mode field encodings
    localparam logic [1:0] BM_FIXED8 = 2'h0;
    localparam logic [1:0] BM_OTF    = 2'h1;
    localparam logic [1:0] BM_CHOP4  = 2'h2;

    // Mode payload layout carried on the address bits of a mode set
    localparam int MB_BM_LO  = 0;
    localparam int MB_DBI    = 2;
    localparam int MB_CWL_LO = 3;
    localparam int MB_AL_LO  = 8;
    localparam int MB_LAT_W  = 5;

    // Clocks from write latency to the edge that ends the data
    localparam logic [CW-1:0] END_EIGHT = 8'h04;
    localparam logic [CW-1:0] END_FIXED = 8'h02;

    // Reset values of latencies and intervals, in clocks
    localparam logic [CW-1:0] CWL_RST     = 8'h09;
    localparam logic [CW-1:0] AL_RST      = 8'h00;
    localparam logic [CW-1:0] TWR_RST     = 8'h0C;
    localparam logic [CW-1:0] WRITE_RECOVERY_INVERTED_RST = 8'h0F;
    localparam logic [CW-1:0] WTR_S_RST   = 8'h02;
    localparam logic [CW-1:0] WTR_L_RST   = 8'h04;
    localparam logic [CW-1:0] ACTIVATE_TO_PRECHARGE_MIN_RST    = 8'h20;

    // APB register byte offsets of the controller
    localparam logic [7:0] REG_CMD  = 8'h00;
    localparam logic [7:0] REG_TIM  = 8'h04;
    localparam logic [7:0] REG_ACTIVATE_TO_PRECHARGE_MIN = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;

    // Command register field positions
    localparam int CF_CMD_LO = 0;
    localparam int CF_BA_LO  = 3;
    localparam int CF_BG_LO  = 5;
    localparam int CF_BC     = 7;
    localparam int CF_AP     = 8;
    localparam int CF_ADR_LO = 16;

    // Chop decision for one read or write command
    function automatic logic wtt_chop(input logic [1:0] bm, input logic bc);
        return (bm == BM_CHOP4) || (bm == BM_OTF && !bc);
    endfunction

    // Larger of two counts, so a new load never shortens a wait
    function automatic logic [CW-1:0] wtt_max(input logic [CW-1:0] a,
                                              input logic [CW-1:0] b);
        return (a > b) ? a : b;
    endfunction

endpackage

/* logic/wtt_cmd_if.sv */
// Command/address path between the controller and the memory device.
// Assumes both ends share clk_sys; the controller drives, the device listens.
`timescale 1ns/1ps
interface wtt_cmd_if;
    import wtt_pkg::*;

    logic            cmd_valid;
    wtt_cmd_t        cmd;
    logic [1:0]      bg;
    logic [1:0]      ba;
    logic            bc_bit;
    logic            ap;
    logic [15:0]     addr;

    // Memory device end
    modport dev (
        input cmd_valid, cmd, bg, ba, bc_bit, ap, addr
    );

    // Controller end
    modport ctl (
        output cmd_valid, cmd, bg, ba, bc_bit, ap, addr
    );
endinterface

/* logic/wtt_dev.sv */
// Device end: burst selection, write data end and auto precharge timing.
// Assumes the controller keeps all command spacing; no checks are made here.
`timescale 1ns/1ps
module wtt_dev
    import wtt_pkg::*;
#(
    parameter logic [CW-1:0] WRITE_RECOVERY_TIME     = TWR_RST,
    parameter logic [CW-1:0] WRITE_RECOVERY_INVERTED = WRITE_RECOVERY_INVERTED_RST
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Command path
    wtt_cmd_if.dev          cif,
    // Mode state
    output logic [1:0]      burst_mode_q,
    output logic            dbi_en_q,
    output logic [CW-1:0]   wl_q,
    // Last read or write burst kind
    output logic            burst_eight_q,
    output logic            chop_four_q,
    // Write data end and internal precharge
    output logic            write_done_q,
    output logic [3:0]      done_bank_q,
    output logic            int_pre_q,
    output logic [3:0]      pre_bank_q
);

    typedef struct packed {
        logic [1:0]                 bm;
        logic                       data_bus_inversion;
        logic [CW-1:0]              al;
        logic [CW-1:0]              cas_write_latency;
        logic [CW-1:0]              wl;
        logic                       eight;
        logic                       chop;
        logic                       done;
        logic [3:0]                 done_bank;
        logic                       pre;
        logic [3:0]                 pre_bank;
        wtt_ph_t [NBANK-1:0]        ph;
        logic [NBANK-1:0][CW-1:0]   cnt;
        logic [NBANK-1:0]           ap;
    } wtt_dev_st_t;

    wtt_dev_st_t q;
    wtt_dev_st_t d;

    // Next state of all trackers and mode bits
    always_comb begin
        logic [CW-1:0] wl;
        logic [CW-1:0] twr_sel;
        logic [3:0]    bank;
        logic          chop;
        wl      = '0;
        twr_sel = '0;
        bank    = '0;
        chop    = 1'b0;
        d       = q;
        d.done  = 1'b0;
        d.pre   = 1'b0;
        // latency is additive plus CAS write
        wl      = q.al + q.cas_write_latency;
        twr_sel = q.data_bus_inversion ? WRITE_RECOVERY_INVERTED : WRITE_RECOVERY_TIME;
        // Downward walk so the lowest bank ending this cycle is the one reported
        for (int i = NBANK - 1; i >= 0; i--) begin
            case (q.ph[i])
                PH_DATA: begin
                    if (q.cnt[i] <= 8'h01) begin
                        d.done      = 1'b1;
                        d.done_bank = 4'(i);
                        d.ph[i]     = q.ap[i] ? PH_REC : PH_IDLE;
                        d.cnt[i]    = twr_sel;
                    end else begin
                        d.cnt[i] = q.cnt[i] - 8'h01;
                    end
                end
                PH_REC: begin
                    if (q.cnt[i] <= 8'h01) begin
                        d.pre      = 1'b1;
                        d.pre_bank = 4'(i);
                        d.ph[i]    = PH_IDLE;
                    end else begin
                        d.cnt[i] = q.cnt[i] - 8'h01;
                    end
                end
                default: begin
                    d.ph[i] = PH_IDLE;
                end
            endcase
        end
        // Command decode; anything else passes untouched
        bank = {cif.bg, cif.ba};
        chop = wtt_chop(q.bm, cif.bc_bit);
        // deselect and others leave trackers alone
        if (cif.cmd_valid) begin
            case (cif.cmd)
                CMD_MRS: begin
                    d.bm  = cif.addr[MB_BM_LO +: 2];
                    d.data_bus_inversion = cif.addr[MB_DBI];
                    d.cas_write_latency = CW'(cif.addr[MB_CWL_LO +: MB_LAT_W]);
                    d.al  = CW'(cif.addr[MB_AL_LO +: MB_LAT_W]);
                end
                CMD_WR: begin
                    d.eight    = !chop;
                    d.chop     = chop;
                    d.ph[bank] = PH_DATA;
                    d.ap[bank] = cif.ap;
                    // Fixed chop ends two clocks sooner than the rest
                    d.cnt[bank] = wl + ((q.bm == BM_CHOP4) ? END_FIXED
                                                            : END_EIGHT);
                end
                CMD_RD: begin
                    d.eight = !chop;
                    d.chop  = chop;
                end
                default: begin
                    d.eight = q.eight;
                end
            endcase
        end
        // registered sum keeps the latency output a flop
        d.wl = d.al + d.cas_write_latency;
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q     <= '0;
            q.cas_write_latency <= CWL_RST;
            q.al  <= AL_RST;
            q.wl  <= CWL_RST + AL_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign burst_mode_q  = q.bm;
    assign dbi_en_q      = q.data_bus_inversion;
    assign wl_q          = q.wl;
    assign burst_eight_q = q.eight;
    assign chop_four_q   = q.chop;
    assign write_done_q  = q.done;
    assign done_bank_q   = q.done_bank;
    assign int_pre_q     = q.pre;
    assign pre_bank_q    = q.pre_bank;

endmodule // wtt_dev

/* bench/wtt_asserts.sv */
// Checker for the command path and device outputs of the turnaround pair.
// Assumes timing registers keep their reset values during the run.
`timescale 1ns/1ps
module wtt_asserts
    import wtt_pkg::*;
(
    // Clock and reset
    input wire logic          clk_sys,
    input wire logic          resetn,
    // Command path
    input wire logic          cmd_valid,
    input wtt_cmd_t           cmd,
    input wire logic [1:0]    bg,
    input wire logic [1:0]    ba,
    input wire logic          bc_bit,
    input wire logic [15:0]   addr,
    // Device outputs
    input wire logic [1:0]    burst_mode_q,
    input wire logic          dbi_en_q,
    input wire logic [CW-1:0] wl_q,
    input wire logic          burst_eight_q,
    input wire logic          chop_four_q,
    input wire logic          write_done_q,
    input wire logic          int_pre_q,
    input wire logic [3:0]    pre_bank_q
);
    logic [CW-1:0] age_q, aage_q, wl_at_q, end_c, rec_c;
    logic [1:0]    bm_at_q;
    logic          dbi_at_q, wr, rw;
    logic [3:0]    wbank_q, abank_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Decoded command strobes and latched write context
    assign wr    = cmd_valid && cmd == CMD_WR;
    assign rw    = cmd_valid && (cmd == CMD_WR || cmd == CMD_RD);
    assign end_c = (bm_at_q == BM_CHOP4) ? END_FIXED : END_EIGHT;
    assign rec_c = dbi_at_q ? WRITE_RECOVERY_INVERTED_RST : TWR_RST;

    // Ages saturate so an old write never looks recent
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            age_q <= 8'hFF;
            aage_q <= 8'hFF;
            wl_at_q <= 8'h00;
            bm_at_q <= 2'h0;
            dbi_at_q <= 1'b0;
            wbank_q <= 4'h0;
            abank_q <= 4'h0;
        end else begin
            age_q <= wr ? 8'h01 : age_q + {7'h00, age_q != 8'hFF};
            aage_q <= (cmd_valid && cmd == CMD_ACT) ? 8'h01
                    : aage_q + {7'h00, aage_q != 8'hFF};
            if (wr) begin
                wl_at_q <= wl_q;
                bm_at_q <= burst_mode_q;
                dbi_at_q <= dbi_en_q;
                wbank_q <= {bg, ba};
            end
            if (cmd_valid && cmd == CMD_ACT)
                abank_q <= {bg, ba};
        end
    end

    idle_des_a: assert property (!cmd_valid |-> cmd == CMD_DES)
        else $error("idle command is not deselect");
    eight_sel_a: assert property (rw && (burst_mode_q == BM_FIXED8 ||
        (burst_mode_q == BM_OTF && bc_bit)) |=> burst_eight_q && !chop_four_q)
        else $error("eight beat burst not selected");
    otf_chop_a: assert property (rw && burst_mode_q == BM_OTF &&
        !bc_bit |=> chop_four_q && !burst_eight_q)
        else $error("per command chop not selected");
    fixed_chop_a: assert property (rw && burst_mode_q == BM_CHOP4
        |=> chop_four_q && !burst_eight_q)
        else $error("fixed chop not selected");
    lat_sum_a: assert property (cmd_valid && cmd == CMD_MRS |=>
        wl_q == {3'h0, $past(addr[12:8])} + {3'h0, $past(addr[7:3])})
        else $error("write latency is not the sum");
    data_end_a: assert property (write_done_q |->
        age_q == wl_at_q + end_c + 8'h01)
        else $error("write data end at wrong cycle");
    auto_pre_a: assert property (int_pre_q |-> pre_bank_q == wbank_q &&
        age_q == wl_at_q + end_c + rec_c + 8'h01)
        else $error("internal precharge at wrong cycle");
    rd_short_a: assert property (cmd_valid && cmd == CMD_RD &&
        bg != wbank_q[3:2] |-> age_q >= wl_at_q + end_c + WTR_S_RST)
        else $error("read too soon in other group");
    rd_long_a: assert property (cmd_valid && cmd == CMD_RD &&
        bg == wbank_q[3:2] |-> age_q >= wl_at_q + end_c + WTR_L_RST)
        else $error("read too soon in same group");
    pre_rec_a: assert property (cmd_valid && cmd == CMD_PRE &&
        {bg, ba} == wbank_q |-> age_q >= wl_at_q + end_c + rec_c)
        else $error("precharge before write recovery");
    pre_activate_to_precharge_min_a: assert property (cmd_valid && cmd == CMD_PRE &&
        {bg, ba} == abank_q |-> aage_q >= ACTIVATE_TO_PRECHARGE_MIN_RST)
        else $error("precharge before activate minimum");

    // Main scenarios reached
    cover property (cmd_valid && cmd == CMD_RD && age_q < 8'h20);
    cover property (int_pre_q);
    cover property (cmd_valid && cmd == CMD_PRE && {bg, ba} == wbank_q);
endmodule // wtt_asserts

/* bench/wtt_bench.sv */
// Bench for the turnaround pair: APB command writes, gaps on the path.
// Assumes a held command is accepted at once and issues only later.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
    err_total++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module wtt_bench;
    import wtt_pkg::*;

    logic          clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd_w;
    logic [1:0]    burst_mode_q;
    logic          dbi_en_q, burst_eight_q, chop_four_q, err_w;
    logic          write_done_q, int_pre_q;
    logic [CW-1:0] wl_q;
    logic [3:0]    done_bank_q, pre_bank_q, pb, db;
    int            err_total, checks_done, cyc, exp_g;
    int            wr_c, rd_c, pre_c, act_c, done_c, ipre_c;

    wtt_cmd_if cif ();
    wtt_ctl i_wtt_ctl (.clk_sys, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .cif(cif.ctl));
    wtt_dev i_wtt_dev (.clk_sys, .resetn, .cif(cif.dev), .burst_mode_q,
        .dbi_en_q, .wl_q, .burst_eight_q, .chop_four_q, .write_done_q,
        .done_bank_q, .int_pre_q, .pre_bank_q);
    wtt_asserts u_chk (.clk_sys, .resetn, .cmd_valid(cif.cmd_valid),
        .cmd(cif.cmd), .bg(cif.bg), .ba(cif.ba), .bc_bit(cif.bc_bit),
        .addr(cif.addr), .burst_mode_q, .dbi_en_q, .wl_q, .burst_eight_q,
        .chop_four_q, .write_done_q, .int_pre_q, .pre_bank_q);

    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Event log with pre-edge values, so no race with the flops
    always @(posedge clk_sys) begin
        cyc++;
        if (cif.cmd_valid === 1'b1)
            case (cif.cmd)
                CMD_WR:  wr_c = cyc;
                CMD_RD:  rd_c = cyc;
                CMD_PRE: pre_c = cyc;
                CMD_ACT: act_c = cyc;
                default: ;
            endcase
        if (write_done_q === 1'b1) begin
            done_c = cyc;
            db = done_bank_q;
        end
        if (int_pre_q === 1'b1) begin
            ipre_c = cyc;
            pb = pre_bank_q;
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd_w = prdata;
        err_w = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rd_w)
    endtask

    // Queue one command and wait for the edge at which the device takes it
    task automatic go(input wtt_cmd_t c, input logic [3:0] bk,
                      input logic bc, input logic ap, input logic [15:0] pl);
        apb(1'b1, REG_CMD, {pl, 7'h00, ap, bc, bk, c});
        // A held command is answered at once but issues later
        do @(posedge clk_sys); while (cif.cmd_valid !== 1'b1);
        @(negedge clk_sys);
    endtask

    task automatic mode(input logic [1:0] bm, input logic data_bus_inversion,
                        input logic [4:0] al);
        go(CMD_MRS, 4'h0, 1'b0, 1'b0, {3'h0, al, 5'h09, data_bus_inversion, bm});
    endtask

    // Hang guard well above the length of the tests
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("timeout reached");
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values, write back, refused place
        chk_rd(REG_TIM, 32'h04020F0C);
        chk_rd(REG_ACTIVATE_TO_PRECHARGE_MIN, 32'h00000020);
        chk_rd(REG_STAT, 32'h00090000);
        apb(1'b1, REG_TIM, 32'h04020F0C);
        chk_rd(REG_TIM, 32'h04020F0C);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        `CHK("wr slverr", 1'b1, err_w)
        chk_rd(8'h10, 32'h0);
        `CHK("rd slverr", 1'b1, err_w)
        mode(BM_OTF, 1'b0, 5'h02);
        `CHK("wl", 8'h0B, wl_q)
        chk_rd(REG_STAT, 32'h02090010);
        mode(BM_OTF, 1'b0, 5'h00);
        $display("test registers done");
        // Write to read, other group then same group
        go(CMD_ACT, 4'h0, 1'b0, 1'b0, 16'h0);
        go(CMD_WR, 4'h0, 1'b1, 1'b0, 16'h0);
        `CHK("eight", 1'b1, burst_eight_q)
        go(CMD_RD, 4'h4, 1'b1, 1'b0, 16'h0);
        `CHK("rd gap s", 15, rd_c - wr_c)
        go(CMD_WR, 4'h0, 1'b0, 1'b0, 16'h0);
        `CHK("chop otf", 1'b1, chop_four_q)
        go(CMD_RD, 4'h1, 1'b0, 1'b0, 16'h0);
        `CHK("rd gap l", 17, rd_c - wr_c)
        $display("test turnaround done");
        // Precharge held by the activate minimum
        go(CMD_ACT, 4'h8, 1'b0, 1'b0, 16'h0);
        go(CMD_WR, 4'h8, 1'b1, 1'b0, 16'h0);
        go(CMD_PRE, 4'h8, 1'b0, 1'b0, 16'h0);
        exp_g = (act_c + 32 > wr_c + 25) ? act_c + 32 - wr_c : 25;
        `CHK("pre gap", exp_g, pre_c - wr_c)
        $display("test precharge done");
        // Auto precharge after recovery
        go(CMD_WR, 4'hD, 1'b1, 1'b1, 16'h0);
        repeat (35) @(posedge clk_sys);
        `CHK("done at", 14, done_c - wr_c)
        `CHK("done bank", 4'hD, db)
        `CHK("ipre at", 26, ipre_c - wr_c)
        `CHK("ipre bank", 4'hD, pb)
        $display("test auto precharge done");
        // Fixed chop ignores the select bit
        mode(BM_CHOP4, 1'b0, 5'h00);
        go(CMD_WR, 4'h4, 1'b1, 1'b0, 16'h0);
        `CHK("chop fix", 1'b1, chop_four_q)
        go(CMD_RD, 4'h8, 1'b1, 1'b0, 16'h0);
        `CHK("rd gap f", 13, rd_c - wr_c)
        $display("test fixed chop done");
        // Inversion on lengthens recovery
        mode(BM_FIXED8, 1'b1, 5'h00);
        go(CMD_WR, 4'h2, 1'b0, 1'b0, 16'h0);
        `CHK("eight m0", 1'b1, burst_eight_q)
        go(CMD_PRE, 4'h2, 1'b0, 1'b0, 16'h0);
        `CHK("pre gap d", 28, pre_c - wr_c)
        $display("test inversion done");
        repeat (40) @(posedge clk_sys);
        end_sim();
    end
endmodule // wtt_bench
